// ==== hdl/map_select_pkg.sv ====
`default_nettype none
package map_select_pkg;

  // --------------------------------------------------------------
  // device addresses and register layout
  // --------------------------------------------------------------
  localparam logic [7:0] MAIN_WR_ADDR_LO   = 8'h40;
  localparam logic [7:0] MAIN_WR_ADDR_HI   = 8'h42;
  localparam logic [7:0] SEL_OFFSET        = 8'h0E;
  localparam int         SEL_LSB           = 5;
  localparam int         SEL_MSB           = 6;
  localparam logic [7:0] SEL_RESET         = 8'h00;
  localparam logic [1:0] SEL_USER          = 2'h0;
  localparam logic [1:0] SEL_INTR_VBI      = 2'h1;
  localparam logic [1:0] SEL_USER2         = 2'h2;
  localparam logic [1:0] SEL_RESERVED      = 2'h3;
  localparam logic [7:0] PP_ADDR_OFFSET    = 8'hFD;
  localparam logic [7:0] PP_ADDR_RESET     = 8'h00;
  localparam logic [7:0] PP_ADDR_SUGGESTED = 8'h84;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    MAP_NONE,
    MAP_USER,
    MAP_INTR_VBI,
    MAP_USER2,
    MAP_POSTPROC
  } map_t;

  typedef enum logic [1:0] {
    SESS_IDLE,
    SESS_MAIN,
    SESS_POSTPROC
  } session_t;

  typedef struct packed {
    logic [7:0] sub;
    logic [7:0] wdata;
  } access_t;

  typedef struct packed {
    logic       write;
    logic [7:0] sub;
    logic [7:0] wdata;
  } fwd_access_t;

endpackage : map_select_pkg
`default_nettype wire

// ==== hdl/serial_register_map_select.sv ====
// Functional notes
// - exactly two maps: main and postprocessor
// - main map answers 0x40, or 0x42 pin high
// - select 00 reaches user sub map
// - select 01 reaches interrupt and VBI map
// - select 10 reaches second user sub map
// - reset selects the user sub map
// - all sub maps share the main address
// - postprocessor address from 0xFD bits 7:1
// - address resets zero; silent until programmed
// - postprocessor decode ignores pin and select
// - pin is address bit 1; bit 0 reads
`timescale 1ns/1ps
`default_nettype none

module serial_register_map_select #(
  parameter int DATA_W = 8
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        clk_en,
  input  wire logic                        address_select_pin,
  input  wire logic                        dev_addr_valid,
  input  wire logic [7:0]                  dev_addr,
  output logic                             dev_addr_match,
  input  wire logic                        txn_end,
  input  wire logic                        acc_valid,
  input  wire map_select_pkg::access_t     acc,
  output logic                             acc_ack,
  output logic                             fwd_valid_r,
  output map_select_pkg::map_t             fwd_map_r,
  output map_select_pkg::fwd_access_t      fwd_acc_r,
  output logic                             local_hit_r,
  output logic [7:0]                       local_rdata_r,
  output logic [1:0]                       sub_map_select,
  output logic [7:0]                       postproc_addr
);

  if (DATA_W != 8) begin : g_bad_width
    $error("serial_register_map_select: register data must be 8 bits wide");
  end

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  // the synchroniser runs free of clk_en so reset always releases
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // registers held here
  // ------------------------------------------------------------
  logic [7:0]               sub_map_select_reg_r;
  logic [7:0]               postproc_map_address_reg_r;
  map_select_pkg::session_t session_r;
  logic                     dir_read_r;

  assign sub_map_select = sub_map_select_reg_r[map_select_pkg::SEL_MSB:map_select_pkg::SEL_LSB];
  assign postproc_addr  = postproc_map_address_reg_r;

  // ------------------------------------------------------------
  // device address decode
  // ------------------------------------------------------------
  logic main_hit;
  logic pp_hit;
  logic pp_enabled;
  logic [6:0] main_addr7;

  // pin level lands on bit 1 of the 8-bit address; bit 0 is direction
  assign main_addr7 = address_select_pin ? map_select_pkg::MAIN_WR_ADDR_HI[7:1]
                                         : map_select_pkg::MAIN_WR_ADDR_LO[7:1];
  assign main_hit   = (dev_addr[7:1] == main_addr7);
  // a zero address keeps the postprocessor map off the bus
  assign pp_enabled = (postproc_map_address_reg_r[7:1] != 7'h00);
  // neither the pin nor the select field takes part here
  assign pp_hit     = pp_enabled && (dev_addr[7:1] == postproc_map_address_reg_r[7:1]);
  assign dev_addr_match = dev_addr_valid && (main_hit || pp_hit);

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      session_r  <= map_select_pkg::SESS_IDLE;
      dir_read_r <= 1'b0;
    end else if (clk_en) begin
      if (dev_addr_valid) begin
        dir_read_r <= dev_addr[0];
        // main wins if both maps were given the same address
        if (main_hit) begin
          session_r <= map_select_pkg::SESS_MAIN;
        end else if (pp_hit) begin
          session_r <= map_select_pkg::SESS_POSTPROC;
        end else begin
          session_r <= map_select_pkg::SESS_IDLE;
        end
      end else if (txn_end) begin
        session_r <= map_select_pkg::SESS_IDLE;
      end
    end
  end

  // ------------------------------------------------------------
  // access routing
  // ------------------------------------------------------------
  logic               in_main;
  logic               sel_local;
  logic               pp_local;
  logic               reserved_sel;
  map_select_pkg::map_t target_map;

  assign in_main      = (session_r == map_select_pkg::SESS_MAIN);
  assign reserved_sel = (sub_map_select == map_select_pkg::SEL_RESERVED);
  // the select byte stays reachable from every sub map, so 11 can be left
  assign sel_local    = in_main && (acc.sub == map_select_pkg::SEL_OFFSET);
  assign pp_local     = in_main && (sub_map_select == map_select_pkg::SEL_USER)
                        && (acc.sub == map_select_pkg::PP_ADDR_OFFSET);

  always_comb begin
    target_map = map_select_pkg::MAP_NONE;
    case (session_r)
      map_select_pkg::SESS_POSTPROC: begin
        target_map = map_select_pkg::MAP_POSTPROC;
      end
      map_select_pkg::SESS_MAIN: begin
        case (sub_map_select)
          map_select_pkg::SEL_USER:     target_map = map_select_pkg::MAP_USER;
          map_select_pkg::SEL_INTR_VBI: target_map = map_select_pkg::MAP_INTR_VBI;
          map_select_pkg::SEL_USER2:    target_map = map_select_pkg::MAP_USER2;
          default:                      target_map = map_select_pkg::MAP_NONE;
        endcase
      end
      default: begin
        target_map = map_select_pkg::MAP_NONE;
      end
    endcase
  end

  logic is_local;
  assign is_local = sel_local || pp_local;
  // reserved select refuses everything but the select byte itself
  assign acc_ack  = acc_valid && (is_local || (target_map != map_select_pkg::MAP_NONE));

  // ------------------------------------------------------------
  // local register writes
  // ------------------------------------------------------------
  logic local_wr;
  assign local_wr = clk_en && acc_valid && !dir_read_r;

  // selection holds until the host writes it back
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sub_map_select_reg_r <= map_select_pkg::SEL_RESET;
    end else if (local_wr && sel_local) begin
      sub_map_select_reg_r <= acc.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      postproc_map_address_reg_r <= map_select_pkg::PP_ADDR_RESET;
    end else if (local_wr && pp_local) begin
      postproc_map_address_reg_r <= acc.wdata;
    end
  end

  // ------------------------------------------------------------
  // answers and forwarding
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      local_hit_r   <= 1'b0;
      local_rdata_r <= 8'h00;
    end else if (clk_en) begin
      local_hit_r <= acc_valid && is_local;
      if (acc_valid && sel_local) begin
        local_rdata_r <= sub_map_select_reg_r;
      end else if (acc_valid && pp_local) begin
        local_rdata_r <= postproc_map_address_reg_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fwd_valid_r <= 1'b0;
      fwd_map_r   <= map_select_pkg::MAP_NONE;
      fwd_acc_r   <= '0;
    end else if (clk_en) begin
      fwd_valid_r <= acc_valid && !is_local && (target_map != map_select_pkg::MAP_NONE);
      if (acc_valid && !is_local) begin
        fwd_map_r       <= target_map;
        fwd_acc_r.write <= !dir_read_r;
        fwd_acc_r.sub   <= acc.sub;
        fwd_acc_r.wdata <= acc.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  function automatic map_select_pkg::map_t sel_to_map(input logic [1:0] s);
    case (s)
      map_select_pkg::SEL_USER:     sel_to_map = map_select_pkg::MAP_USER;
      map_select_pkg::SEL_INTR_VBI: sel_to_map = map_select_pkg::MAP_INTR_VBI;
      map_select_pkg::SEL_USER2:    sel_to_map = map_select_pkg::MAP_USER2;
      default:                      sel_to_map = map_select_pkg::MAP_NONE;
    endcase
  endfunction : sel_to_map

  sequence s_main_fwd_access;
    clk_en && acc_valid && in_main && !is_local;
  endsequence

  sequence s_pp_addr_write;
    clk_en && acc_valid && !dir_read_r && pp_local;
  endsequence

  a_main_addr_hit: assert property (@(posedge clk) disable iff (!rst_n_r)
    (dev_addr_valid && dev_addr[7:1] == (address_select_pin ? 7'h21 : 7'h20)) |-> dev_addr_match)
    else $error("main map address not matched");

  a_pp_silent_zero: assert property (@(posedge clk) disable iff (!rst_n_r)
    (dev_addr_valid && postproc_map_address_reg_r[7:1] == 7'h00 && !main_hit) |-> !dev_addr_match)
    else $error("postprocessor map answered while unprogrammed");

  a_pp_session_open: assert property (@(posedge clk) disable iff (!rst_n_r)
    (clk_en && dev_addr_valid && !main_hit && pp_enabled
     && dev_addr[7:1] == postproc_map_address_reg_r[7:1])
    |=> (session_r == map_select_pkg::SESS_POSTPROC))
    else $error("postprocessor session not opened");

  a_miss_goes_idle: assert property (@(posedge clk) disable iff (!rst_n_r)
    (clk_en && dev_addr_valid && !dev_addr_match) |=> (session_r == map_select_pkg::SESS_IDLE))
    else $error("unmatched address left a session open");

  a_user_after_reset: assert property (@(posedge clk) disable iff (!rst_b)
    (rst_n_r && !$past(rst_n_r)) |-> (sub_map_select == map_select_pkg::SEL_USER))
    else $error("select not at user sub map after reset");

  a_sub_map_route: assert property (@(posedge clk) disable iff (!rst_n_r)
    (s_main_fwd_access and (clk_en && !reserved_sel))
    |=> fwd_valid_r && fwd_map_r == sel_to_map($past(sub_map_select)))
    else $error("main access routed to wrong sub map");

  a_reserved_no_fwd: assert property (@(posedge clk) disable iff (!rst_n_r)
    (s_main_fwd_access and (clk_en && reserved_sel)) |=> !fwd_valid_r ##0 !$past(acc_ack))
    else $error("access forwarded under reserved select");

  a_pp_addr_store: assert property (@(posedge clk) disable iff (!rst_n_r)
    s_pp_addr_write |=> (postproc_map_address_reg_r == $past(acc.wdata)))
    else $error("postprocessor address write not stored");

  a_dir_write_bit: assert property (@(posedge clk) disable iff (!rst_n_r)
    (clk_en && dev_addr_valid && main_hit) ##2 s_main_fwd_access
    |=> fwd_acc_r.write == !$past(dev_addr[0], 3))
    else $error("direction bit not honoured");

endmodule : serial_register_map_select

`default_nettype wire

// ==== testbench/bus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------------------
// host side: address byte, register bytes, stop
// --------------------------------------------------------------
module bus_master_model (
  input  wire logic               clk,
  input  wire logic               dev_addr_match,
  input  wire logic               acc_ack,
  output logic                    dev_addr_valid,
  output logic [7:0]              dev_addr,
  output logic                    txn_end,
  output logic                    acc_valid,
  output map_select_pkg::access_t acc
);
  initial begin
    dev_addr_valid = 1'b0;
    dev_addr       = 8'h00;
    txn_end        = 1'b0;
    acc_valid      = 1'b0;
    acc            = '0;
  end
  // released lines show the inverse, never a stale copy
  task automatic start(input logic [7:0] a, output logic m);
    @(negedge clk);
    dev_addr_valid = 1'b1;
    dev_addr       = a;
    #1 m = dev_addr_match;
    @(negedge clk);
    dev_addr_valid = 1'b0;
    dev_addr       = ~a;
  endtask : start
  task automatic access(input logic [7:0] s, input logic [7:0] d, output logic k);
    @(negedge clk);
    acc_valid = 1'b1;
    acc       = {s, d};
    #1 k = acc_ack;
    @(negedge clk);
    acc_valid = 1'b0;
    acc       = ~{s, d};
  endtask : access
  task automatic stop();
    @(negedge clk);
    txn_end = 1'b1;
    @(negedge clk);
    txn_end = 1'b0;
  endtask : stop
  task automatic prog(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d);
    logic m;
    logic k;
    start(a, m);
    access(s, d, k);
    stop();
  endtask : prog
endmodule : bus_master_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module tb_top;
  typedef struct packed {
    logic pin; logic [1:0] sel; logic [7:0] addr; logic [7:0] sub;
    logic match; logic ack; map_select_pkg::map_t map;
  } row_t;
  logic clk, rst_b, pin, m, k, ce;
  logic dav, te, av, match, ack, fv, lh;
  logic [7:0] da, lrd, ppa, pa;
  logic [1:0] sel;
  map_select_pkg::access_t acc;
  map_select_pkg::map_t fm;
  map_select_pkg::fwd_access_t fa, ef;
  row_t rows [8];
  int n_mismatch = 0;
  int comparisons = 0;
  bus_master_model m_u (.clk(clk), .dev_addr_match(match), .acc_ack(ack),
    .dev_addr_valid(dav), .dev_addr(da), .txn_end(te), .acc_valid(av), .acc(acc));
  serial_register_map_select dut_u (.clk(clk), .rst_b(rst_b), .clk_en(ce),
    .address_select_pin(pin), .dev_addr_valid(dav), .dev_addr(da),
    .dev_addr_match(match), .txn_end(te), .acc_valid(av), .acc(acc), .acc_ack(ack),
    .fwd_valid_r(fv), .fwd_map_r(fm), .fwd_acc_r(fa), .local_hit_r(lh),
    .local_rdata_r(lrd), .sub_map_select(sel), .postproc_addr(ppa));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
  endtask : do_reset
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    pin = 1'b0;
    ce = 1'b1;
    rows = '{'{1'b0, 2'h0, 8'h40, 8'h10, 1'b1, 1'b1, map_select_pkg::MAP_USER},
             '{1'b1, 2'h1, 8'h43, 8'h10, 1'b1, 1'b1, map_select_pkg::MAP_INTR_VBI},
             '{1'b0, 2'h2, 8'h41, 8'h80, 1'b1, 1'b1, map_select_pkg::MAP_USER2},
             '{1'b1, 2'h0, 8'h40, 8'h10, 1'b0, 1'b0, map_select_pkg::MAP_NONE},
             '{1'b1, 2'h3, 8'h42, 8'h10, 1'b1, 1'b0, map_select_pkg::MAP_NONE},
             '{1'b0, 2'h2, 8'h84, 8'h10, 1'b1, 1'b1, map_select_pkg::MAP_POSTPROC},
             '{1'b1, 2'h1, 8'h85, 8'h20, 1'b1, 1'b1, map_select_pkg::MAP_POSTPROC},
             '{1'b0, 2'h0, 8'h44, 8'h10, 1'b0, 1'b0, map_select_pkg::MAP_NONE}};
    do_reset();
    `CHK("sel_rst", 2'h0, sel)
    `CHK("pp_rst", 8'h00, ppa)
    m_u.start(8'h84, m);
    `CHK("pp_silent", 1'b0, m)
    m_u.start(8'h40, m);
    m_u.access(8'h10, 8'h5A, k);
    `CHK("dflt_map", map_select_pkg::MAP_USER, fm)
    m_u.stop();
    m_u.prog(8'h40, 8'hFD, 8'h84);
    `CHK("pp_addr", 8'h84, ppa)
    m_u.start(8'h41, m);
    m_u.access(8'hFD, 8'h00, k);
    `CHK("rd_hit", 1'b1, lh)
    `CHK("rd_val", 8'h84, lrd)
    m_u.stop();
    foreach (rows[i]) begin
      pin = rows[i].pin;
      pa = rows[i].pin ? 8'h42 : 8'h40;
      m_u.prog(pa, 8'h0E, {1'b0, rows[i].sel, 5'h00});
      m_u.start(rows[i].addr, m);
      `CHK("match", rows[i].match, m)
      m_u.access(rows[i].sub, 8'hA5, k);
      `CHK("ack", rows[i].ack, k)
      `CHK("fwd_v", rows[i].map != map_select_pkg::MAP_NONE, fv)
      ef = {~rows[i].addr[0], rows[i].sub, 8'hA5};
      if (rows[i].map != map_select_pkg::MAP_NONE) begin
        `CHK("fwd_map", rows[i].map, fm)
        `CHK("fwd_acc", ef, fa)
      end
      m_u.stop();
      m_u.prog(pa, 8'h0E, 8'h00);
    end
    pin = 1'b0;
    // bit 0 of the address register plays no part in decode
    m_u.prog(8'h40, 8'hFD, 8'h85);
    m_u.start(8'h84, m);
    `CHK("pp_bit0", 1'b1, m)
    m_u.stop();
    m_u.prog(8'h40, 8'h0E, 8'h60);
    m_u.start(8'h40, m);
    m_u.access(8'hFD, 8'h11, k);
    `CHK("rsv_ack", 1'b0, k)
    m_u.stop();
    `CHK("rsv_keep", 8'h85, ppa)
    m_u.prog(8'h40, 8'h0E, 8'h00);
    `CHK("rsv_leave", 2'h0, sel)
    m_u.access(8'h10, 8'h00, k);
    `CHK("no_sess", 1'b0, k)
    // clk_en low must freeze the select register
    ce = 1'b0;
    m_u.prog(8'h40, 8'h0E, 8'h40);
    `CHK("ce_hold", 2'h0, sel)
    ce = 1'b1;
    m_u.prog(8'h40, 8'h0E, 8'h40);
    do_reset();
    `CHK("sel_rst2", 2'h0, sel)
    `CHK("pp_rst2", 8'h00, ppa)
    summarize();
  end
endmodule : tb_top
`default_nettype wire
